//--- hw/sfpa_regs.svh
// sfpa constants: opcodes, status layout, protection bounds, sizes
// assumes inclusion by sfpa_top only
`ifndef SFPA_REGS_SVH
`define SFPA_REGS_SVH
`define SFPA_OP_ENABLE_WRITE_CMD 8'h06
`define SFPA_OP_DISABLE_WRITE_CMD 8'h04
`define SFPA_OP_STATUS_READ_CMD 8'h05
`define SFPA_OP_STATUS_WRITE_CMD 8'h01
`define SFPA_OP_READ 8'h03
`define SFPA_OP_WRITE 8'h02
`define SFPA_ST_PIN_PROTECT_ENABLE 7
`define SFPA_ST_BP_HI 3
`define SFPA_ST_BP_LO 2
`define SFPA_ST_WEL 1
`define SFPA_ST_RESET 8'h00
`define SFPA_ADDR_W 11
`define SFPA_ADDR_LAST 11'h7ff
`define SFPA_PROT_QTR 11'h600
`define SFPA_PROT_HALF 11'h400
`endif

//--- hw/sfpa_pkg.sv
// sfpa types: command sequencer states
// assumes nothing of its surroundings
package sfpa_pkg;
    typedef enum logic [7:0] {
        SFPA_IDLE = 8'b0000_0001,
        SFPA_OPC = 8'b0000_0010,
        SFPA_ADDR = 8'b0000_0100,
        SFPA_WDATA = 8'b0000_1000,
        SFPA_RDATA = 8'b0001_0000,
        SFPA_SRD = 8'b0010_0000,
        SFPA_SWR = 8'b0100_0000,
        SFPA_IGN = 8'b1000_0000
    } sfpa_state_t;
endpackage

//--- hw/sfpa_top.sv
// sfpa_top: spi slave with status protection and 2k x 8 byte array
// assumes async spi pins, sampled by ref_clk_i well above twice sck rate
`include "sfpa_regs.svh"
module sfpa_top
    import sfpa_pkg::*;
#(
    parameter int ADDR_W = `SFPA_ADDR_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // spi pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    // control pins
    input wire logic pause_n_i,
    input wire logic wp_n_i
);
    localparam int DEPTH = 1 << ADDR_W;

    function automatic logic is_prot(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
        case (bp)
            2'b01: is_prot = (a >= `SFPA_PROT_QTR);
            2'b10: is_prot = (a >= `SFPA_PROT_HALF);
            2'b11: is_prot = 1'b1;
            default: is_prot = 1'b0;
        endcase
    endfunction

    // two-flop synchronisers plus one stage for edges
    logic [4:0] meta_reg, sync_reg;
    logic cs_d_reg, sck_d_reg, pause_d_reg;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= 5'h19;
            sync_reg <= 5'h19;
            cs_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
            pause_d_reg <= 1'b1;
        end else begin
            meta_reg <= {wp_n_i, pause_n_i, si_i, sck_i, cs_n_i};
            sync_reg <= meta_reg;
            cs_d_reg <= sync_reg[0];
            sck_d_reg <= sync_reg[1];
            pause_d_reg <= sync_reg[3];
        end
    end
    logic cs_s, sck_s, si_s, pause_s, wp_s;
    assign {wp_s, pause_s, si_s, sck_s, cs_s} = sync_reg;

    logic paused_reg;
    logic cs_fall, cs_rise, sck_rise, sck_fall;
    assign cs_fall = !cs_s && cs_d_reg;
    assign cs_rise = cs_s && !cs_d_reg;
    assign sck_rise = sck_s && !sck_d_reg && !cs_s && !paused_reg;
    assign sck_fall = !sck_s && sck_d_reg && !cs_s && !paused_reg;

    // pause latch, cleared on deselect, otherwise changes only with sck low
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            paused_reg <= 1'b0;
        end else if (cs_s) begin
            paused_reg <= 1'b0;
        end else if (!sck_s && pause_s != pause_d_reg) begin
            paused_reg <= !pause_s;
        end
    end

    // status and array storage
    logic wel_reg, clr_pend_reg, stopped_reg;
    logic [2:0] nv_reg = 3'b000;
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] status;
    assign status = {nv_reg[2], 3'b000, nv_reg[1:0], wel_reg, 1'b0};

    sfpa_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] sh_in_reg;
    logic [2:0] addr_hi_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] sh_out_reg;
    logic [7:0] rx_byte;
    logic byte_done, mem_we, sr_we;
    assign rx_byte = {sh_in_reg, si_s};
    assign byte_done = sck_rise && bit_cnt_reg == 3'd7;
    assign mem_we = byte_done && state_reg == SFPA_WDATA && !stopped_reg && wel_reg
        && !is_prot(nv_reg[1:0], addr_reg);
    assign sr_we = byte_done && state_reg == SFPA_SWR && wel_reg
        && !(nv_reg[2] && !wp_s);

    // bit counter and input shifter
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt_reg <= 3'd0;
            sh_in_reg <= 7'h00;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'd0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            sh_in_reg <= rx_byte[6:0];
        end
    end

    // command sequencer
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= SFPA_IDLE;
            addr_hi_reg <= 3'd0;
        end else if (cs_s) begin
            state_reg <= SFPA_IDLE;
        end else if (cs_fall) begin
            state_reg <= SFPA_OPC;
        end else if (byte_done) begin
            case (state_reg)
                SFPA_OPC: begin
                    case (rx_byte)
                        `SFPA_OP_STATUS_READ_CMD: state_reg <= SFPA_SRD;
                        `SFPA_OP_STATUS_WRITE_CMD: state_reg <= SFPA_SWR;
                        `SFPA_OP_READ, `SFPA_OP_WRITE: state_reg <= SFPA_ADDR;
                        default: state_reg <= SFPA_IGN;
                    endcase
                    addr_hi_reg <= 3'd0;
                end
                SFPA_ADDR: begin
                    if (addr_hi_reg[0] == 1'b0 && bit_cnt_reg == 3'd7 && state_reg == SFPA_ADDR
                        && addr_hi_reg != 3'd7) begin
                        addr_hi_reg <= 3'd7;
                    end
                    if (addr_hi_reg == 3'd7) begin
                        state_reg <= clr_pend_reg ? SFPA_WDATA : SFPA_RDATA;
                    end
                end
                SFPA_SRD, SFPA_SWR: state_reg <= SFPA_IGN;
                SFPA_WDATA, SFPA_RDATA, SFPA_IGN: state_reg <= state_reg;
                default: state_reg <= SFPA_IGN;
            endcase
        end
    end

    // address capture and burst increment
    logic [2:0] addr_top_reg;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_reg <= '0;
            addr_top_reg <= 3'd0;
            stopped_reg <= 1'b0;
        end else if (cs_fall) begin
            stopped_reg <= 1'b0;
        end else if (byte_done) begin
            case (state_reg)
                SFPA_ADDR: begin
                    if (addr_hi_reg != 3'd7) begin
                        addr_top_reg <= rx_byte[2:0];
                    end else begin
                        addr_reg <= ADDR_W'({addr_top_reg, rx_byte});
                    end
                end
                SFPA_WDATA: begin
                    if (stopped_reg || is_prot(nv_reg[1:0], addr_reg)) begin
                        stopped_reg <= 1'b1;
                    end else begin
                        addr_reg <= addr_reg + 1'b1;
                    end
                end
                SFPA_RDATA: addr_reg <= addr_reg + 1'b1;
                default: addr_reg <= addr_reg;
            endcase
        end
    end

    // array write, no reset so contents persist
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem_reg[addr_reg] <= rx_byte;
        end
    end

    // protect enable and block-protect bits, no reset
    always_ff @(posedge ref_clk_i) begin
        if (sr_we) begin
            nv_reg <= {rx_byte[`SFPA_ST_PIN_PROTECT_ENABLE], rx_byte[`SFPA_ST_BP_HI],
                rx_byte[`SFPA_ST_BP_LO]};
        end
    end

    // write-enable latch and its deferred clear
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wel_reg <= 1'b0;
            clr_pend_reg <= 1'b0;
        end else if (cs_rise) begin
            if (clr_pend_reg) begin
                wel_reg <= 1'b0;
            end
            clr_pend_reg <= 1'b0;
        end else if (cs_fall) begin
            clr_pend_reg <= 1'b0;
        end else if (byte_done && state_reg == SFPA_OPC) begin
            case (rx_byte)
                `SFPA_OP_ENABLE_WRITE_CMD: wel_reg <= 1'b1;
                `SFPA_OP_DISABLE_WRITE_CMD, `SFPA_OP_STATUS_WRITE_CMD, `SFPA_OP_WRITE: clr_pend_reg <= 1'b1;
                default: clr_pend_reg <= 1'b0;
            endcase
        end
    end

    // output shifter, loaded at byte end, shifted on falling sck
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh_out_reg <= 8'h00;
            so_o <= 1'b0;
        end else if (byte_done && state_reg == SFPA_OPC) begin
            sh_out_reg <= status;
        end else if (byte_done && state_reg == SFPA_ADDR && addr_hi_reg == 3'd7) begin
            sh_out_reg <= mem_reg[ADDR_W'({addr_top_reg, rx_byte})];
        end else if (byte_done && state_reg == SFPA_RDATA) begin
            sh_out_reg <= mem_reg[addr_reg + 1'b1];
        end else if (sck_fall && (state_reg == SFPA_RDATA || state_reg == SFPA_SRD)) begin
            so_o <= sh_out_reg[7];
            sh_out_reg <= {sh_out_reg[6:0], 1'b0};
        end
    end

    // drive enable, low only in read states while selected and not paused
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            so_oe_n_o <= 1'b1;
        end else begin
            so_oe_n_o <= !(!cs_s && !paused_reg
                && (state_reg == SFPA_RDATA || state_reg == SFPA_SRD));
        end
    end

    AST_RSVD_ZERO: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        sck_fall && state_reg == SFPA_SRD && bit_cnt_reg inside {3'd1, 3'd2, 3'd3, 3'd7}
        |=> !so_o) else $error("reserved status bit read as one");
    AST_WEL_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cs_rise && clr_pend_reg |=> !wel_reg) else $error("latch not cleared");
    AST_ARRAY_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        mem_we |-> wel_reg && !is_prot(nv_reg[1:0], addr_reg)) else $error("bad write");
    AST_WP_BLOCK: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        byte_done && state_reg == SFPA_SWR && nv_reg[2] && !wp_s |=> $stable(nv_reg))
        else $error("status write not blocked");
    AST_ADDR_WRAP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        byte_done && state_reg == SFPA_RDATA && addr_reg == `SFPA_ADDR_LAST
        |=> addr_reg == '0) else $error("address did not wrap");
    AST_STOP_DISCARD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        stopped_reg |-> !mem_we && $stable(addr_reg)) else $error("write after stop");
    AST_DESELECT_HIZ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cs_s |-> ##2 so_oe_n_o) else $error("output driven while deselected");
    AST_PAUSE_FREEZE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        paused_reg && !cs_s |=> $stable(bit_cnt_reg) && $stable(addr_reg))
        else $error("state moved while paused");
    AST_IGN_HIZ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        state_reg == SFPA_IGN |=> so_oe_n_o) else $error("output driven when ignoring");
    // latch, status and protection checks on the synchronised link
    AST_WEL_SET: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        byte_done && state_reg == SFPA_OPC && rx_byte == `SFPA_OP_ENABLE_WRITE_CMD |=> wel_reg)
        else $error("latch not set by enable");
    AST_WEL_KEPT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        sr_we |=> wel_reg)
        else $error("status write changed latch early");
    AST_SR_NEEDS_WEL: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        byte_done && state_reg == SFPA_SWR && !wel_reg |=> $stable(nv_reg))
        else $error("status written without latch");
    AST_PROT_RANGE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        mem_we |-> nv_reg[1:0] == 2'b00 || (nv_reg[1:0] == 2'b01 && addr_reg < `SFPA_PROT_QTR)
        || (nv_reg[1:0] == 2'b10 && addr_reg < `SFPA_PROT_HALF)) else $error("protected write");
    AST_SRD_ONE_BYTE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        byte_done && state_reg == SFPA_SRD |=> state_reg == SFPA_IGN)
        else $error("status read longer than one byte");
endmodule

//--- verification/sfpa_master.sv
// sfpa_master: spi bus master model, mode 0, with pause and protect pins
// assumes ref_clk_i at 100 MHz; one sck period is eight of its cycles
module sfpa_master (
    // clock
    input wire logic ref_clk_i,
    // spi pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_n_i,
    // control pins
    output logic pause_n_o,
    output logic wp_n_o,
    // checked bytes
    output logic [7:0] rx_o,
    output logic rx_v_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic so_last;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        pause_n_o = 1'b1;
        wp_n_o = 1'b1;
        rx_o = 8'h00;
        rx_v_o = 1'b0;
        so_last = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge ref_clk_i);
    endtask
    task automatic sel();
        cs_n_o = 1'b0;
        half();
    endtask
    task automatic desel();
        half();
        cs_n_o = 1'b1;
        repeat (8) @(negedge ref_clk_i);
    endtask
    // msb first; a released line shows the inverse of its last level
    task automatic xfer(input logic [7:0] tx, input bit chk);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            half();
            sck_o = 1'b1;
            repeat (3) @(negedge ref_clk_i);
            rx[i] = so_oe_n_i ? ~so_last : so_i;
            if (!so_oe_n_i) so_last = so_i;
            @(negedge ref_clk_i);
            sck_o = 1'b0;
        end
        if (chk) begin
            rx_o = rx;
            rx_v_o = 1'b1;
            @(negedge ref_clk_i);
            rx_v_o = 1'b0;
        end
    endtask
    // pause with sck low, clocks run meanwhile
    task automatic hold();
        pause_n_o = 1'b0;
        repeat (3) begin
            half();
            sck_o = 1'b1;
            half();
            sck_o = 1'b0;
        end
        half();
        pause_n_o = 1'b1;
        half();
    endtask
endmodule

//--- verification/sfpa_top_bench.sv
// sfpa_top_bench: self-checking bench for sfpa_top
// assumes sfpa_master drives all spi and control pins at ref clock falls
module sfpa_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cs_n, sck, si, so, so_oe_n, pause_n, wp_n, rx_v;
    logic [7:0] rx, v0, v1;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    sfpa_top dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .pause_n_i(pause_n), .wp_n_i(wp_n));
    sfpa_master m (.ref_clk_i(ref_clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so),
        .so_oe_n_i(so_oe_n), .pause_n_o(pause_n), .wp_n_o(wp_n), .rx_o(rx), .rx_v_o(rx_v));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            complete_run();
        end
    end
    always @(posedge rx_v) begin
        checks_done++;
        if (exp_q.size() == 0 || rx !== exp_q.pop_front()) begin
            err_count++;
            $display("wrong value at %0t: read byte %h", $time, rx);
        end
    end
    task automatic chk_hiz();
        checks_done++;
        if (so_oe_n !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: serial output driven", $time);
        end
    endtask
    task automatic op1(input logic [7:0] op);
        m.sel();
        m.xfer(op, 1'b0);
        m.desel();
    endtask
    task automatic status_read_cmd(input logic [7:0] e);
        exp_q.push_back(e);
        m.sel();
        m.xfer(8'h05, 1'b0);
        m.xfer(8'($urandom), 1'b1);
        m.desel();
    endtask
    task automatic status_write_cmd(input logic [7:0] v);
        op1(8'h06);
        m.sel();
        m.xfer(8'h01, 1'b0);
        m.xfer(v, 1'b0);
        m.desel();
    endtask
    task automatic adr_op(input logic [7:0] op, input logic [10:0] a);
        m.sel();
        m.xfer(op, 1'b0);
        m.xfer({5'h1f, a[10:8]}, 1'b0);
        m.xfer(a[7:0], 1'b0);
    endtask
    task automatic wr(input bit en, input logic [10:0] a, input logic [7:0] d0, d1);
        if (en) op1(8'h06);
        adr_op(8'h02, a);
        m.xfer(d0, 1'b0);
        m.xfer(d1, 1'b0);
        m.desel();
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] e0, e1, input bit pz);
        exp_q.push_back(e0);
        exp_q.push_back(e1);
        adr_op(8'h03, a);
        m.xfer(8'($urandom), 1'b1);
        if (pz) m.hold();
        m.xfer(8'($urandom), 1'b1);
        m.desel();
        chk_hiz();
    endtask
    function automatic bit prot(input int c, input logic [10:0] a);
        return c == 3 || (c == 2 && a >= 11'h400) || (c == 1 && a >= 11'h600);
    endfunction
    initial begin
        logic [10:0] b;
        void'($urandom(32'ha150_6c50));
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        status_read_cmd(8'h00);
        op1(8'h06);
        status_read_cmd(8'h02);
        op1(8'h04);
        status_read_cmd(8'h00);
        status_write_cmd(8'hff);
        status_read_cmd(8'h8c);
        $display("test status commands done");
        for (int c = 0; c < 4; c++) begin
            b = (c == 3) ? 11'h000 : (c == 2) ? 11'h400 : 11'h600;
            v0 = 8'($urandom);
            v1 = ~v0;
            status_write_cmd(8'h00);
            wr(1'b1, b - 11'h001, v0, v0);
            status_write_cmd(8'(c << 2));
            wr(1'b1, b - 11'h001, v1, v1);
            rd(b - 11'h001, prot(c, b - 11'h001) ? v0 : v1, prot(c, b) ? v0 : v1, 1'b0);
        end
        $display("test block protect done");
        op1(8'h06);
        resetn = 1'b0;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        status_read_cmd(8'h0c);
        v0 = 8'($urandom);
        v1 = 8'($urandom);
        status_write_cmd(8'h00);
        wr(1'b1, 11'h7ff, v0, v1);
        wr(1'b0, 11'h7ff, ~v0, ~v1);
        rd(11'h7ff, v0, v1, 1'b1);
        status_read_cmd(8'h00);
        $display("test burst and pause done");
        status_write_cmd(8'h80);
        m.wp_n_o = 1'b0;
        status_write_cmd(8'h0c);
        status_read_cmd(8'h80);
        wr(1'b1, 11'h0aa, v1, v0);
        rd(11'h0aa, v1, v0, 1'b0);
        m.wp_n_o = 1'b1;
        status_write_cmd(8'h00);
        status_read_cmd(8'h00);
        m.sel();
        m.xfer(8'h01, 1'b0);
        m.xfer(8'h8c, 1'b0);
        m.desel();
        status_read_cmd(8'h00);
        m.sel();
        m.xfer(8'hff, 1'b0);
        m.xfer(8'h06, 1'b0);
        chk_hiz();
        m.desel();
        status_read_cmd(8'h00);
        $display("test pin protect and bad opcode done");
        repeat (10) @(negedge ref_clk);
        complete_run();
    end
endmodule
